// ==== logic/ecit_clkgen.sv ====
`timescale 1ns/1ps
module ecit_clkgen
  import ecit_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [1:0] countClockSel,
  input  wire logic       run,
  input  wire logic       watchClk,
  output logic            incPulse,
  output logic            sampleRise
);

  logic [ECIT_PRE_W-1:0] pre_r, pre_nxt;
  logic                  wSync1_r, wSync2_r, wPrev_r, wHalf_r;
  logic                  wSync1_nxt, wSync2_nxt, wPrev_nxt, wHalf_nxt;
  logic                  selPrev_r, selPrev_nxt;
  logic                  selLevel;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pre_nxt     = pre_r + 1'b1;
    wSync1_nxt  = watchClk;
    wSync2_nxt  = wSync1_r;
    wPrev_nxt   = wSync2_r;
    wHalf_nxt   = (wSync2_r & ~wPrev_r) ? ~wHalf_r : wHalf_r;
    selPrev_nxt = selLevel;
  end

  always_comb begin
    case (countClockSel)
      ECIT_CKS_DIV64: selLevel = pre_r[ECIT_PRE_BIT64];
      ECIT_CKS_DIV32: selLevel = pre_r[ECIT_PRE_BIT32];
      ECIT_CKS_DIV2:  selLevel = pre_r[ECIT_PRE_BIT2];
      ECIT_CKS_WATCH: selLevel = wHalf_r;
      default:        selLevel = pre_r[ECIT_PRE_BIT64];
    endcase
  end

  // A select change from high to low is a falling edge too
  assign incPulse   = run & selPrev_r & ~selLevel;
  assign sampleRise = run & ~selPrev_r & selLevel;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_r     <= '0;
      wSync1_r  <= 1'b0;
      wSync2_r  <= 1'b0;
      wPrev_r   <= 1'b0;
      wHalf_r   <= 1'b0;
      selPrev_r <= 1'b0;
    end else begin
      pre_r     <= pre_nxt;
      wSync1_r  <= wSync1_nxt;
      wSync2_r  <= wSync2_nxt;
      wPrev_r   <= wPrev_nxt;
      wHalf_r   <= wHalf_nxt;
      selPrev_r <= selPrev_nxt;
    end
  end

endmodule

// ==== logic/ecit_filter.sv ====
`timescale 1ns/1ps
module ecit_filter
  import ecit_pkg::*;
#(
  parameter int STAGES = ECIT_FILT_STAGES
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic sampleEn,
  input  wire logic din,
  output logic      dout
);

  initial begin
    if (STAGES < 2) $error("ecit_filter needs at least two stages");
  end

  logic [STAGES-1:0] stage_r, stage_nxt;
  logic              out_r, out_nxt;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    stage_nxt = sampleEn ? {stage_r[STAGES-2:0], din} : stage_r;
    // Output moves only on full agreement, otherwise it holds
    if (&stage_r) begin
      out_nxt = 1'b1;
    end else if (~|stage_r) begin
      out_nxt = 1'b0;
    end else begin
      out_nxt = out_r;
    end
  end

  assign dout = out_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage_r <= '0;
      out_r   <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      out_r   <= out_nxt;
    end
  end

endmodule

// ==== logic/ecit_pkg.sv ====
package ecit_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] ECIT_OFF_MODE     = 3'h0;
  localparam logic [2:0] ECIT_OFF_COUNT    = 3'h1;
  localparam logic [2:0] ECIT_OFF_RISECAP  = 3'h2;
  localparam logic [2:0] ECIT_OFF_FALLCAP  = 3'h3;
  localparam logic [2:0] ECIT_OFF_PORTONE  = 3'h4;
  localparam logic [2:0] ECIT_OFF_PORTTWO  = 3'h5;
  localparam logic [2:0] ECIT_OFF_REQFLAG  = 3'h6;
  localparam logic [2:0] ECIT_OFF_IRQEN    = 3'h7;

  // Field positions inside the mode register and the one-bit port, flag and enable registers
  localparam int ECIT_BIT_WRAP_HI   = 7;
  localparam int ECIT_BIT_WRAP_LO   = 6;
  localparam int ECIT_BIT_FUNC_EN   = 0;
  localparam int ECIT_BIT_FILT_EN   = 0;
  localparam int ECIT_BIT_REQ       = 0;
  localparam int ECIT_BIT_IRQ_EN    = 0;

  // Reset value and count maximum
  localparam logic [7:0] ECIT_RST_BYTE = 8'h00;
  localparam logic [7:0] ECIT_COUNT_MAX = 8'hFF;

  // Count clock select encodings
  localparam logic [1:0] ECIT_CKS_DIV64 = 2'h0;
  localparam logic [1:0] ECIT_CKS_DIV32 = 2'h1;
  localparam logic [1:0] ECIT_CKS_DIV2  = 2'h2;
  localparam logic [1:0] ECIT_CKS_WATCH = 2'h3;

  // Prescaler width and the bit that forms each divided level
  localparam int ECIT_PRE_W     = 6;
  localparam int ECIT_PRE_BIT64 = 5;
  localparam int ECIT_PRE_BIT32 = 4;
  localparam int ECIT_PRE_BIT2  = 0;

  // Filter depth and settling count
  localparam int         ECIT_FILT_STAGES = 5;
  localparam logic [2:0] ECIT_SETTLE_DONE = 3'h5;

  typedef enum logic [2:0] {
    ECIT_PM_ACTIVE    = 3'h0,
    ECIT_PM_SLEEP     = 3'h1,
    ECIT_PM_WATCH     = 3'h2,
    ECIT_PM_SUBACTIVE = 3'h3,
    ECIT_PM_SUBSLEEP  = 3'h4,
    ECIT_PM_STANDBY   = 3'h5
  } ecit_pmode_t;

  typedef struct packed {
    logic       wrapWhileHighFlag;
    logic       wrapWhileLowFlag;
    logic       wrapIrqEnable;
    logic       irqEdgePolarity;
    logic       countClearSelHi;
    logic       countClearSelLo;
    logic [1:0] countClockSel;
  } ecit_mode_t;

endpackage

// ==== logic/edge_capture_interval_timer.sv ====
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Clear count on selected capture edges
// - Reset inits; watch and standby modes halt or hold, sleep runs
// - Halved watch clock synchronised to system clock
// - Sub modes run only on watch clock
// - Falling count-clock edge makes increment pulse
// - Select change high to low increments once
// - Enable with pin high gives false rise
// - Disable with pin high gives false fall
// - Enable, or disable with pin high, during filter settling gives false edge
// - Filter disable mid-settle gives pin-direction edge
// - Unassigned pin gives low capture signal
// - Matching false edge sets request flag
// - Edges copy count into capture registers
// - Clock select picks one of four clocks
// - Five agreeing samples change filter output
// - Overflow sets wrap flag by level
module edge_capture_interval_timer
  import ecit_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [2:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata,
  input  wire logic [2:0]  powerMode,
  input  wire logic        watchClk,
  input  wire logic        capturePin,
  output logic             edgeTimerIrq,
  output logic             captureLevel
);

  initial begin
    if (CNT_W != 8) $error("edge_capture_interval_timer supports an 8-bit count only");
  end

  ecit_mode_t       mode_r, mode_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic [CNT_W-1:0] riseCap_r, riseCap_nxt;
  logic [CNT_W-1:0] fallCap_r, fallCap_nxt;
  logic             funcEn_r, funcEn_nxt;
  logic             filtEn_r, filtEn_nxt;
  logic             reqFlag_r, reqFlag_nxt;
  logic             irqEn_r, irqEn_nxt;
  logic             capPrev_r, capPrev_nxt;
  logic [2:0]       settle_r, settle_nxt;
  logic [7:0]       rdata_r, rdata_nxt;

  logic             incPulse, sampleRise, sampleEn, filtOut;
  logic             gatedPin, capSig, run, modeWritable;
  logic             riseEv, fallEv, forcedRise, forcedFall, clearNow, wrapNow;
  logic             wrMode, wrPortOne, wrPortTwo, wrFlag, wrIrqEn, settling;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Operating state

  always_comb begin
    case (ecit_pmode_t'(powerMode))
      ECIT_PM_ACTIVE:    run = 1'b1;
      ECIT_PM_SLEEP:     run = 1'b1;
      ECIT_PM_SUBACTIVE: run = (mode_r.countClockSel == ECIT_CKS_WATCH);
      ECIT_PM_SUBSLEEP:  run = (mode_r.countClockSel == ECIT_CKS_WATCH);
      default:           run = 1'b0;
    endcase
    // Mode register only takes writes while the CPU is really running
    modeWritable = (ecit_pmode_t'(powerMode) == ECIT_PM_ACTIVE) ||
                   (ecit_pmode_t'(powerMode) == ECIT_PM_SUBACTIVE);
  end

  ecit_clkgen u_clkgen (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .countClockSel (mode_r.countClockSel),
    .run           (run),
    .watchClk      (watchClk),
    .incPulse      (incPulse),
    .sampleRise    (sampleRise)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Capture path

  assign gatedPin = funcEn_r & capturePin;
  // Filter off samples every system clock, on samples the count clock
  assign sampleEn = run & (filtEn_r ? sampleRise : 1'b1);

  ecit_filter #(
    .STAGES (ECIT_FILT_STAGES)
  ) u_filter (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .sampleEn (sampleEn),
    .din      (gatedPin),
    .dout     (filtOut)
  );

  // Dropping the filter switches straight to the live pin
  assign capSig       = filtEn_r ? filtOut : gatedPin;
  assign captureLevel = capPrev_r;
  assign settling     = filtEn_r & (settle_r < ECIT_SETTLE_DONE);

  always_comb begin
    forcedRise = 1'b0;
    forcedFall = 1'b0;
    if (settling && wrPortOne && funcEn_nxt != funcEn_r) begin
      if (funcEn_nxt) begin
        forcedRise = capturePin;
        forcedFall = ~capturePin;
      end else begin
        forcedFall = capturePin;
      end
    end
  end

  // Pin-function toggles surface here as edges of the gated signal
  assign riseEv = run & ((capSig & ~capPrev_r) | forcedRise);
  assign fallEv = run & ((~capSig & capPrev_r) | forcedFall);

  always_comb begin
    capPrev_nxt = run ? capSig : capPrev_r;
    settle_nxt  = settle_r;
    if (!filtEn_r) begin
      settle_nxt = '0;
    end else if (sampleEn && settling) begin
      settle_nxt = settle_r + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Count, capture and flags

  assign clearNow = (riseEv & mode_r.countClearSelHi) |
                    (fallEv & mode_r.countClearSelLo);
  assign wrapNow  = incPulse & ~clearNow & (count_r == ECIT_COUNT_MAX);

  assign wrMode    = regWr & hit(regAddr, ECIT_OFF_MODE);
  assign wrPortOne = regWr & hit(regAddr, ECIT_OFF_PORTONE);
  assign wrPortTwo = regWr & hit(regAddr, ECIT_OFF_PORTTWO);
  assign wrFlag    = regWr & hit(regAddr, ECIT_OFF_REQFLAG);
  assign wrIrqEn   = regWr & hit(regAddr, ECIT_OFF_IRQEN);

  always_comb begin
    count_nxt = count_r;
    if (clearNow) begin
      count_nxt = '0;
    end else if (incPulse) begin
      count_nxt = count_r + 1'b1;
    end
    // Each register moves only on its own edge
    riseCap_nxt = riseEv ? count_r : riseCap_r;
    fallCap_nxt = fallEv ? count_r : fallCap_r;
  end

  always_comb begin
    mode_nxt = mode_r;
    if (wrMode && modeWritable) begin
      mode_nxt.wrapIrqEnable     = regWdata[5];
      mode_nxt.irqEdgePolarity   = regWdata[4];
      mode_nxt.countClearSelHi   = regWdata[3];
      mode_nxt.countClearSelLo   = regWdata[2];
      mode_nxt.countClockSel     = regWdata[1:0];
      // Wrap flags clear by writing zero only
      if (!regWdata[ECIT_BIT_WRAP_HI]) mode_nxt.wrapWhileHighFlag = 1'b0;
      if (!regWdata[ECIT_BIT_WRAP_LO]) mode_nxt.wrapWhileLowFlag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (wrapNow && capSig)  mode_nxt.wrapWhileHighFlag = 1'b1;
    if (wrapNow && !capSig) mode_nxt.wrapWhileLowFlag = 1'b1;
  end

  always_comb begin
    funcEn_nxt  = wrPortOne ? regWdata[ECIT_BIT_FUNC_EN] : funcEn_r;
    filtEn_nxt  = wrPortTwo ? regWdata[ECIT_BIT_FILT_EN] : filtEn_r;
    irqEn_nxt   = wrIrqEn ? regWdata[ECIT_BIT_IRQ_EN] : irqEn_r;
    reqFlag_nxt = reqFlag_r;
    if (wrFlag && !regWdata[ECIT_BIT_REQ]) reqFlag_nxt = 1'b0;
    if ((riseEv && !mode_r.irqEdgePolarity) ||
        (fallEv && mode_r.irqEdgePolarity)) begin
      reqFlag_nxt = 1'b1;
    end
    if (wrapNow && mode_r.wrapIrqEnable) reqFlag_nxt = 1'b1;
  end

  assign edgeTimerIrq = reqFlag_r & irqEn_r;

  //////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe

  always_comb begin
    rdata_nxt = '0;
    if (regRd) begin
      case (regAddr)
        ECIT_OFF_MODE:    rdata_nxt = mode_r;
        ECIT_OFF_COUNT:   rdata_nxt = count_r;
        ECIT_OFF_RISECAP: rdata_nxt = riseCap_r;
        ECIT_OFF_FALLCAP: rdata_nxt = fallCap_r;
        ECIT_OFF_PORTONE: rdata_nxt = {7'h00, funcEn_r};
        ECIT_OFF_PORTTWO: rdata_nxt = {7'h00, filtEn_r};
        ECIT_OFF_REQFLAG: rdata_nxt = {7'h00, reqFlag_r};
        ECIT_OFF_IRQEN:   rdata_nxt = {7'h00, irqEn_r};
        default:          rdata_nxt = '0;
      endcase
    end
  end

  assign regRdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Registers, one process per group

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_r   <= ECIT_RST_BYTE;
      riseCap_r <= ECIT_RST_BYTE;
      fallCap_r <= ECIT_RST_BYTE;
    end else begin
      count_r   <= count_nxt;
      riseCap_r <= riseCap_nxt;
      fallCap_r <= fallCap_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r <= ecit_mode_t'(ECIT_RST_BYTE);
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      funcEn_r  <= 1'b0;
      filtEn_r  <= 1'b0;
      reqFlag_r <= 1'b0;
      irqEn_r   <= 1'b0;
    end else begin
      funcEn_r  <= funcEn_nxt;
      filtEn_r  <= filtEn_nxt;
      reqFlag_r <= reqFlag_nxt;
      irqEn_r   <= irqEn_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      capPrev_r <= 1'b0;
      settle_r  <= '0;
    end else begin
      capPrev_r <= capPrev_nxt;
      settle_r  <= settle_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= ECIT_RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule

// ==== tb/ecit_props.sv ====
`timescale 1ns/1ps
module ecit_props
  import ecit_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic [2:0] powerMode,
  input wire logic       watchClk,
  input wire logic       capturePin,
  input wire logic       edgeTimerIrq,
  input wire logic       captureLevel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Shadows of the port-side enables, and the standby count-read hold
  logic       funcEn_r, filtEn_r, irqEn_r, rdCnt_r, heldV_r;
  logic [7:0] held_r;
  wire        halt = powerMode == ECIT_PM_STANDBY;
  always_ff @(posedge clk_sys) begin
    if (srst || (regWr && regAddr == ECIT_OFF_PORTONE)) funcEn_r <= !srst && regWdata[0];
    if (srst || (regWr && regAddr == ECIT_OFF_PORTTWO)) filtEn_r <= !srst && regWdata[0];
    if (srst || (regWr && regAddr == ECIT_OFF_IRQEN)) irqEn_r <= !srst && regWdata[0];
    rdCnt_r <= !srst && regRd && regAddr == ECIT_OFF_COUNT;
    heldV_r <= !srst && halt && (heldV_r || rdCnt_r);
    if (rdCnt_r && !heldV_r) held_r <= regRdata;
  end
  ////////////////////////////////////////
  sequence s_enWr; regWr && regAddr == ECIT_OFF_IRQEN; endsequence
  sequence s_enRd; regRd && regAddr == ECIT_OFF_IRQEN; endsequence
  property p_rstQuiet;
    @(posedge clk_sys) disable iff (1'b0)
      srst |=> regRdata == 8'h00 && !edgeTimerIrq && !captureLevel;
  endproperty
  property p_rdIdle; !regRd |=> regRdata == 8'h00; endproperty
  property p_irqEnRead; s_enWr ##1 s_enRd |=> regRdata[0] == $past(regWdata[0], 2); endproperty
  property p_irqOff; regWr && regAddr == ECIT_OFF_IRQEN && !regWdata[0] |=> !edgeTimerIrq;
  endproperty
  property p_irqNeedsEn; $rose(edgeTimerIrq) |-> irqEn_r; endproperty
  // Filter off: pin reaches the capture level one edge later
  property p_follow;
    funcEn_r && !filtEn_r && powerMode == ECIT_PM_ACTIVE |=> captureLevel == $past(capturePin);
  endproperty
  property p_unassigned;
    $past(!funcEn_r && !filtEn_r && powerMode == ECIT_PM_ACTIVE) |-> !captureLevel;
  endproperty
  property p_haltHold; rdCnt_r && heldV_r |-> regRdata == held_r; endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("state not cleared by reset");
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside its slot");
  a_irqEnRead: assert property (p_irqEnRead) else $error("irq enable readback");
  a_irqOff: assert property (p_irqOff) else $error("irq stays after disable");
  a_irqNeedsEn: assert property (p_irqNeedsEn) else $error("irq without enable");
  a_follow: assert property (p_follow) else $error("capture level lags pin");
  a_unassigned: assert property (p_unassigned) else $error("capture high unassigned");
  a_haltHold: assert property (p_haltHold) else $error("count moved in standby");
endmodule

bind edge_capture_interval_timer ecit_props u_props (
  .clk_sys, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .powerMode, .watchClk, .capturePin, .edgeTimerIrq, .captureLevel
);

// ==== tb/ecit_pulse_src.sv ====
`timescale 1ns/1ps
module ecit_pulse_src (
  input wire logic clk_sys,
  output logic     pin
);
  initial pin = 1'b0;
  // Level held n whole cycles; callers keep n at 2 or more unfiltered
  task automatic drive(input logic lvl, input int n);
    @(posedge clk_sys);
    pin <= lvl;
    repeat (n - 1) @(posedge clk_sys);
  endtask
endmodule

// ==== tb/edge_capture_interval_timer_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module edge_capture_interval_timer_tb;
  import ecit_pkg::*;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       watchClk = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [2:0] powerMode = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, rv, old;
  logic       edgeTimerIrq, captureLevel, capturePin;
  int         num_errors = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         k, h, l;
  logic [5:0] preRef = 6'h00;
  // Free-running divider reference, restarted by reset
  always @(posedge clk_sys) preRef <= srst ? 6'h00 : preRef + 6'h01;
  edge_capture_interval_timer uut (
    .clk_sys, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .powerMode, .watchClk, .capturePin, .edgeTimerIrq, .captureLevel
  );
  ecit_pulse_src src (.clk_sys, .pin(capturePin));
  ////////////////////////////////////////
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc % 6 == 0) watchClk <= ~watchClk;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One call per edge, so no strobe is assigned twice in a step
  task automatic cy(input logic w, r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWdata <= d;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d); cy(1, 0, a, d); cy(0, 0, a, d);
  endtask
  task automatic rd(input logic [2:0] a); cy(0, 1, a, 0); cy(0, 0, a, 0); #1 rv = regRdata;
  endtask
  task automatic waitc(input int n); repeat (n) @(posedge clk_sys); endtask
  // Capture timing allows one count of slack either way
  function automatic logic near(input logic [7:0] g, input int e);
    return !$isunknown(g) && int'(g) <= e + 1 && int'(g) + 1 >= e;
  endfunction
  ////////////////////////////////////////
  initial begin
    k = $urandom(71641);
    waitc(16);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      `CHK(rv, 8'h00)
    end
    $display("reset test done");
    for (int s = 0; s < 3; s++) begin
      k = 1 + $urandom % 3;
      wr(ECIT_OFF_MODE, 8'(s));
      rd(ECIT_OFF_COUNT);
      old = rv;
      waitc(k * (s == 0 ? 64 : s == 1 ? 32 : 2) - 2);
      rd(ECIT_OFF_COUNT);
      `CHK(8'(rv - old), 8'(k))
    end
    // Phase 32..47: the /64 level is high and the /32 level low, no natural falls
    wr(ECIT_OFF_MODE, 8'h00);
    while (preRef != 6'h20) @(posedge clk_sys);
    for (int j = 1; j >= 0; j--) begin
      rd(ECIT_OFF_COUNT);
      old = rv;
      wr(ECIT_OFF_MODE, 8'(j ? ECIT_CKS_DIV32 : ECIT_CKS_DIV64));
      rd(ECIT_OFF_COUNT);
      `CHK(8'(rv - old), 8'(j))
    end
    $display("rate test done");
    wr(ECIT_OFF_MODE, 8'h0E);
    wr(ECIT_OFF_PORTONE, 8'h01);
    h = 2 * (8 + $urandom % 20);
    l = 2 * (8 + $urandom % 20);
    src.drive(1, h);
    src.drive(0, l);
    src.drive(1, 6);
    rd(ECIT_OFF_FALLCAP);
    `CHK(near(rv, h / 2), 1'b1)
    rd(ECIT_OFF_RISECAP);
    `CHK(near(rv, l / 2), 1'b1)
    src.drive(0, 4);
    wr(ECIT_OFF_PORTONE, 8'h00);
    src.drive(1, 2);
    cy(1, 0, ECIT_OFF_IRQEN, 8'h01);
    rd(ECIT_OFF_IRQEN);
    `CHK(rv[0], 1'b1)
    for (int i = 0; i < 4; i++) begin
      wr(ECIT_OFF_MODE, {3'h0, i[1], 4'h0});
      wr(ECIT_OFF_REQFLAG, 8'h00);
      wr(ECIT_OFF_PORTONE, {7'h0, !i[0]});
      waitc(3);
      rd(ECIT_OFF_REQFLAG);
      `CHK(rv[0], i[0] == i[1])
      `CHK(edgeTimerIrq, i[0] == i[1])
    end
    wr(ECIT_OFF_REQFLAG, 8'h00);
    wr(ECIT_OFF_IRQEN, 8'h00);
    src.drive(0, 3);
    src.drive(1, 3);
    `CHK(captureLevel, 1'b0)
    src.drive(0, 2);
    $display("false edge test done");
    wr(ECIT_OFF_MODE, 8'h12);
    for (int j = 1; j >= 0; j--) begin
      wr(ECIT_OFF_REQFLAG, 8'h00);
      wr(ECIT_OFF_PORTTWO, 8'h01);
      waitc(j ? 0 : 20);
      wr(ECIT_OFF_PORTONE, 8'h01);
      waitc(3);
      rd(ECIT_OFF_REQFLAG);
      `CHK(rv[0], j[0])
      wr(ECIT_OFF_PORTONE, 8'h00);
      wr(ECIT_OFF_PORTTWO, 8'h00);
    end
    wr(ECIT_OFF_PORTTWO, 8'h01);
    wr(ECIT_OFF_MODE, 8'h02);
    src.drive(0, 20);
    wr(ECIT_OFF_PORTONE, 8'h01);
    waitc(12);
    wr(ECIT_OFF_REQFLAG, 8'h00);
    src.drive(1, 1 + $urandom % 3);
    src.drive(0, 20);
    `CHK(captureLevel, 1'b0)
    src.drive(1, 30);
    `CHK(captureLevel, 1'b1)
    src.drive(0, 30);
    wr(ECIT_OFF_REQFLAG, 8'h00);
    src.drive(1, 2);
    wr(ECIT_OFF_PORTTWO, 8'h00);
    waitc(2);
    rd(ECIT_OFF_REQFLAG);
    `CHK(rv[0], 1'b1)
    wr(ECIT_OFF_PORTONE, 8'h00);
    wr(ECIT_OFF_PORTTWO, 8'h00);
    $display("filter test done");
    wr(ECIT_OFF_MODE, 8'h22);
    wr(ECIT_OFF_REQFLAG, 8'h00);
    waitc(520);
    rd(ECIT_OFF_MODE);
    `CHK(rv[7:6], 2'b01)
    rd(ECIT_OFF_REQFLAG);
    `CHK(rv[0], 1'b1)
    wr(ECIT_OFF_MODE, 8'h00);
    wr(ECIT_OFF_REQFLAG, 8'h00);
    @(posedge clk_sys) powerMode <= ECIT_PM_STANDBY;
    rd(ECIT_OFF_COUNT);
    old = rv;
    wr(ECIT_OFF_MODE, 8'h03);
    waitc(150);
    rd(ECIT_OFF_COUNT);
    `CHK(rv, old)
    rd(ECIT_OFF_MODE);
    `CHK(rv, 8'h00)
    @(posedge clk_sys) powerMode <= ECIT_PM_SUBACTIVE;
    for (int j = 0; j < 2; j++) begin
      wr(ECIT_OFF_MODE, j ? 8'h00 : 8'h03);
      rd(ECIT_OFF_COUNT);
      old = rv;
      waitc(200);
      rd(ECIT_OFF_COUNT);
      `CHK(rv != old, j == 0)
    end
    @(posedge clk_sys) powerMode <= ECIT_PM_ACTIVE;
    $display("power mode test done");
    results();
  end
endmodule
